// >>> verilog/mdsl_pkg.sv
// package: constants, types and option tables for the mode decode and setting latch
// Behaviour
// - enable high, mode high: automatic mode, boost or buck chosen from input level.
// - enable high, mode low: forced buck, output tied to input, store charged.
// - enable low, mode low: forced bypass, bypass closed, converters off.
// - enable low, mode high: true shutdown, load cut from input and backup.
// - automatic mode: input below boost target means boost from backup store.
// - automatic mode: input above target plus 0.1 V means follow input and charge.
// - forced buck: charging stops when store reaches termination level.
// - forced buck: charging restarts 75 mV below termination level.
// - each of three selectors resolves to one of sixteen options.
// - detection order: termination, then current, then boost target, after output nears input.
// - each selector steps from lowest option upward, one per 10 us tick.
// - after detection, all three results are latched and used thereafter.
// - selectors are not sampled again while operating.
// - toggling enable redoes detection at next start-up.
// - boost target options map 2.7 V to 5.4 V; open pin is highest.
// - termination options map 1.7 V to 5.4 V; open pin is highest.
// - current option 0 disables charging; open pin gives 600 mA.
// - enable low with mode high enters true shutdown.
package mdsl_pkg;

	localparam int unsigned CLK_HZ       = 25000000;
	localparam int unsigned TICK_NS      = 10000;
	localparam int unsigned TICK_CYC     = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int unsigned N_OPT        = 16;
	localparam logic [3:0]  OPT_RST      = 4'h0;
	localparam logic [3:0]  OPT_OPEN     = 4'hf;
	localparam logic [15:0] BYPASS_MV    = 16'h0064;
	localparam logic [15:0] RECHG_MV     = 16'h004b;

	typedef enum logic [1:0] {
		MDSL_BYPASS,
		MDSL_SHUTDOWN,
		MDSL_FBUCK,
		MDSL_AUTO
	} mdsl_mode_t;

	typedef enum logic [1:0] {
		MDSL_SEL_TERM,
		MDSL_SEL_CURR,
		MDSL_SEL_BOOST
	} mdsl_sel_t;

	typedef struct packed {
		logic [3:0] term;
		logic [3:0] curr;
		logic [3:0] boost;
	} mdsl_set_t;

	typedef struct packed {
		logic bypass_on;
		logic boost_on;
		logic buck_on;
		logic disconnect;
	} mdsl_ctl_t;

	// target levels in mV, index 0 lowest, 15 open pin
	localparam logic [15:0] BOOST_MV [N_OPT] = '{
		16'h0a8c, 16'h0bb8, 16'h0ce4, 16'h0d48, 16'h0d7a, 16'h0dac, 16'h0e10, 16'h0e74,
		16'h0ed8, 16'h0fa0, 16'h1068, 16'h1194, 16'h12c0, 16'h1388, 16'h1450, 16'h1518};
	localparam logic [15:0] TERM_MV [N_OPT] = '{
		16'h06a4, 16'h07d0, 16'h0898, 16'h09c4, 16'h0a28, 16'h0a8c, 16'h0e10, 16'h0e42,
		16'h0e74, 16'h1004, 16'h1036, 16'h1068, 16'h1324, 16'h1388, 16'h13ec, 16'h1518};
	// charge current in 0.1 mA units
	localparam logic [15:0] CURR_DMA [N_OPT] = '{
		16'h0000, 16'h0019, 16'h0032, 16'h0064, 16'h00fa, 16'h01f4, 16'h02ee, 16'h03e8,
		16'h05dc, 16'h07d0, 16'h09c4, 16'h0bb8, 16'h0dac, 16'h0fa0, 16'h1388, 16'h1770};

endpackage

// >>> verilog/mdsl_top.sv
// top: mode decode, selector detection sequencer and charge hysteresis
`timescale 1ns/100ps
module mdsl_top (
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              enable_pin,
	input  wire logic              mode_pin,
	input  wire logic              out_near_in,
	input  wire logic              sel_match,
	input  wire logic [15:0]       vin_mv,
	input  wire logic [15:0]       vsup_mv,
	input  wire logic              apb_psel,
	input  wire logic              apb_penable,
	input  wire logic              apb_pwrite,
	input  wire logic [7:0]        apb_paddr,
	input  wire logic [31:0]       apb_pwdata,
	output logic [31:0]            apb_prdata,
	output logic                   apb_pready,
	output logic                   apb_pslverr,
	output mdsl_pkg::mdsl_sel_t    probe_sel,
	output logic [3:0]             probe_opt,
	output logic                   probe_active,
	output mdsl_pkg::mdsl_ctl_t    ctl,
	output logic [15:0]            charge_termination_level,
	output logic [15:0]            charge_current_level,
	output logic [15:0]            boost_target_level
);

	localparam logic [7:0] A_STAT = 8'h00;
	localparam logic [7:0] A_SET  = 8'h04;
	localparam logic [7:0] A_CTRL = 8'h08;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PROBE, ST_DONE} st_t;

	st_t                 st_r, st_nxt;
	mdsl_pkg::mdsl_sel_t sel_r, sel_nxt;
	logic [3:0]          opt_r, opt_nxt;
	logic [15:0]         tick_r, tick_nxt;
	mdsl_pkg::mdsl_set_t set_r, set_nxt;
	logic                chg_r, chg_nxt;
	logic                ovr_r, ovr_nxt;
	logic                en_d_r;
	logic                tick;
	mdsl_pkg::mdsl_mode_t mode;

	assign tick = (tick_r == 16'(mdsl_pkg::TICK_CYC - 1));

	always_comb begin
		unique case ({enable_pin, mode_pin})
			2'b11:   mode = mdsl_pkg::MDSL_AUTO;
			2'b10:   mode = mdsl_pkg::MDSL_FBUCK;
			2'b00:   mode = mdsl_pkg::MDSL_BYPASS;
			default: mode = mdsl_pkg::MDSL_SHUTDOWN;
		endcase
	end

	always_comb begin
		st_nxt   = st_r;
		sel_nxt  = sel_r;
		opt_nxt  = opt_r;
		tick_nxt = tick_r;
		set_nxt  = set_r;
		if (!enable_pin) begin
			// drop results so the next start-up detects afresh
			st_nxt   = ST_IDLE;
			set_nxt  = '{mdsl_pkg::OPT_RST, mdsl_pkg::OPT_RST, mdsl_pkg::OPT_RST};
			tick_nxt = '0;
		end else begin
			unique case (st_r)
				ST_IDLE: st_nxt = ST_WAIT;
				ST_WAIT: begin
					if (out_near_in) begin
						st_nxt   = ST_PROBE;
						sel_nxt  = mdsl_pkg::MDSL_SEL_TERM;
						opt_nxt  = mdsl_pkg::OPT_RST;
						tick_nxt = '0;
					end
				end
				ST_PROBE: begin
					tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
					if (tick) begin
						// open pin never matches below top, so 15 is forced there
						if (sel_match || opt_r == mdsl_pkg::OPT_OPEN) begin
							unique case (sel_r)
								mdsl_pkg::MDSL_SEL_TERM: begin
									set_nxt.term = opt_r;
									sel_nxt      = mdsl_pkg::MDSL_SEL_CURR;
								end
								mdsl_pkg::MDSL_SEL_CURR: begin
									set_nxt.curr = opt_r;
									sel_nxt      = mdsl_pkg::MDSL_SEL_BOOST;
								end
								default: begin
									set_nxt.boost = opt_r;
									st_nxt        = ST_DONE;
								end
							endcase
							opt_nxt = mdsl_pkg::OPT_RST;
						end else begin
							opt_nxt = opt_r + 4'h1;
						end
					end
				end
				ST_DONE: st_nxt = ST_DONE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r   <= ST_IDLE;
			sel_r  <= mdsl_pkg::MDSL_SEL_TERM;
			opt_r  <= mdsl_pkg::OPT_RST;
			tick_r <= 16'h0000;
			set_r  <= '{mdsl_pkg::OPT_RST, mdsl_pkg::OPT_RST, mdsl_pkg::OPT_RST};
		end else begin
			st_r   <= st_nxt;
			sel_r  <= sel_nxt;
			opt_r  <= opt_nxt;
			tick_r <= tick_nxt;
			set_r  <= set_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] tgt_mv, term_mv;
	logic        done;
	logic [16:0] tgt_hi;

	assign done    = (st_r == ST_DONE);
	assign tgt_mv  = mdsl_pkg::BOOST_MV[set_r.boost];
	assign term_mv = mdsl_pkg::TERM_MV[set_r.term];
	assign tgt_hi  = {1'b0, tgt_mv} + {1'b0, mdsl_pkg::BYPASS_MV};

	always_comb begin
		chg_nxt = chg_r;
		if (mode != mdsl_pkg::MDSL_FBUCK || !done)
			chg_nxt = 1'b1;
		else if (vsup_mv >= term_mv)
			chg_nxt = 1'b0;
		else if ({1'b0, vsup_mv} + {1'b0, mdsl_pkg::RECHG_MV} <= {1'b0, term_mv})
			chg_nxt = 1'b1;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			chg_r  <= 1'b1;
			en_d_r <= 1'b0;
			ovr_r  <= 1'b0;
		end else begin
			chg_r  <= chg_nxt;
			en_d_r <= enable_pin;
			ovr_r  <= ovr_nxt;
		end
	end

	// buck only runs with a nonzero current option
	always_comb begin
		ctl = '0;
		unique case (mode)
			mdsl_pkg::MDSL_BYPASS:   ctl.bypass_on = 1'b1;
			mdsl_pkg::MDSL_SHUTDOWN: ctl.disconnect = 1'b1;
			mdsl_pkg::MDSL_FBUCK: begin
				ctl.bypass_on = 1'b1;
				ctl.buck_on   = done && chg_r && set_r.curr != 4'h0;
			end
			mdsl_pkg::MDSL_AUTO: begin
				if (done && {1'b0, vin_mv} < {1'b0, tgt_mv})
					ctl.boost_on = 1'b1;
				else if (done && {1'b0, vin_mv} >= tgt_hi) begin
					ctl.bypass_on = 1'b1;
					ctl.buck_on   = set_r.curr != 4'h0;
				end else
					ctl.bypass_on = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			charge_termination_level <= 16'h0000;
			charge_current_level     <= 16'h0000;
			boost_target_level       <= 16'h0000;
		end else begin
			charge_termination_level <= done ? term_mv : 16'h0000;
			charge_current_level     <= done ? mdsl_pkg::CURR_DMA[set_r.curr] : 16'h0000;
			boost_target_level       <= done ? tgt_mv : 16'h0000;
		end
	end

	assign probe_sel    = sel_r;
	assign probe_opt    = opt_r;
	assign probe_active = (st_r == ST_PROBE);

	////////////////////////////////////////////////////////////////////////////
	// apb: zero wait; unmapped gives pslverr
	logic acc;
	logic mapped;

	assign acc         = apb_psel && apb_penable;
	assign mapped      = apb_paddr == A_STAT || apb_paddr == A_SET || apb_paddr == A_CTRL;
	assign apb_pready  = 1'b1;
	assign apb_pslverr = acc && !mapped;

	// ctrl bit0: clear sticky enable-drop flag
	always_comb begin
		ovr_nxt = ovr_r;
		if (acc && apb_pwrite && apb_paddr == A_CTRL && apb_pwdata[0])
			ovr_nxt = 1'b0;
		if (en_d_r && !enable_pin)
			ovr_nxt = 1'b1;
	end

	always_comb begin
		apb_prdata = 32'h00000000;
		if (acc && !apb_pwrite) begin
			unique case (apb_paddr)
				A_STAT:  apb_prdata = {22'h000000, ovr_r, chg_r, mode, st_r, ctl};
				A_SET:   apb_prdata = {20'h00000, set_r};
				default: apb_prdata = 32'h00000000;
			endcase
		end
	end

endmodule

// >>> sim/mdsl_props.sv
// checker: mode decode, detection stepping and latched settings
`timescale 1ns/100ps
module mdsl_props (
	input wire logic                mclk,
	input wire logic                rstn,
	input wire logic                enable_pin,
	input wire logic                mode_pin,
	input wire logic [15:0]         vin_mv,
	input wire mdsl_pkg::mdsl_sel_t probe_sel,
	input wire logic [3:0]          probe_opt,
	input wire logic                probe_active,
	input wire mdsl_pkg::mdsl_ctl_t ctl,
	input wire logic [15:0]         charge_termination_level,
	input wire logic [15:0]         boost_target_level
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////////////
	wire logic [5:0] st = {probe_sel, probe_opt};
	AST_BYPASS: assert property (!enable_pin && !mode_pin |-> ctl == 4'b1000)
		else $error("bypass controls wrong");
	AST_SHUTDOWN: assert property (!enable_pin && mode_pin |-> ctl == 4'b0001)
		else $error("shutdown controls wrong");
	// levels are registered behind the state, so they clear one edge after it
	AST_CLEAR: assert property (!enable_pin |-> ##2 (boost_target_level == 16'h0 && !probe_active))
		else $error("settings not cleared");
	AST_STEP: assert property (probe_active && $changed(probe_opt) && probe_opt != 4'h0 |-> probe_opt == $past(probe_opt) + 4'h1)
		else $error("option skipped");
	// one option per tick: next move exactly one tick later
	AST_TICK: assert property (probe_active && $changed(st) |-> ##250 ($changed(st) || !probe_active))
		else $error("tick spacing wrong");
	// entry into probing resets the selector, so only moves inside probing count
	AST_ORDER: assert property (probe_active && $past(probe_active) && $changed(probe_sel) |-> probe_sel - $past(probe_sel) == 1 && probe_opt == 4'h0)
		else $error("selector order wrong");
	AST_HOLD: assert property (enable_pin && $past(enable_pin) && $past(enable_pin, 2) && $past(boost_target_level) != 16'h0 |-> $stable(boost_target_level) && $stable(charge_termination_level))
		else $error("latched setting moved");
	AST_BOOST: assert property (enable_pin && $past(enable_pin) && mode_pin && boost_target_level != 16'h0 && vin_mv < boost_target_level |-> ctl.boost_on && !ctl.buck_on)
		else $error("boost not running");
	CV_DONE: cover property ($rose(boost_target_level != 16'h0));
	CV_OPEN: cover property (probe_active && probe_opt == 4'hf);
	CV_FBUCK: cover property (enable_pin && !mode_pin && ctl.buck_on);
endmodule
bind mdsl_top mdsl_props u_props (.mclk, .rstn, .enable_pin, .mode_pin, .vin_mv, .probe_sel,
	.probe_opt, .probe_active, .ctl, .charge_termination_level, .boost_target_level);

// >>> sim/mdsl_partner.sv
// far-side model: setting resistors seen through the option comparator
`timescale 1ns/100ps
module mdsl_partner (
	input  wire logic                mclk,
	input  wire logic                probe_active,
	input  wire mdsl_pkg::mdsl_sel_t probe_sel,
	input  wire logic [3:0]          probe_opt,
	input  wire logic [11:0]         res_opt,
	output logic                     sel_match
);
	logic junk_r = 1'b0;
	// outside probing the comparator means nothing, so it wanders
	always_ff @(posedge mclk) junk_r <= ~junk_r;
	// option 0 stands for a grounded pin
	assign sel_match = probe_active ? (probe_opt == res_opt[4*(2-probe_sel) +: 4]) : junk_r;
endmodule

// >>> sim/tb_top.sv
// bench: mode table, selector detection, latched settings and charge control
`timescale 1ns/100ps
module tb_top;
	logic                mclk = 1'b0;
	logic                rstn = 1'b0;
	logic                en = 1'b0;
	logic                md = 1'b0;
	logic                near = 1'b0;
	logic [15:0]         vin = 16'h0;
	logic [15:0]         vsup = 16'h0;
	logic [11:0]         res = 12'h0;
	logic [41:0]         req = '0;
	logic                pen = 1'b0;
	logic [31:0]         prdata;
	logic                pready, pslverr, act, match;
	logic [3:0]          opt;
	mdsl_pkg::mdsl_sel_t sel;
	mdsl_pkg::mdsl_ctl_t ctl;
	logic [15:0]         lt, lc, lb, t;
	logic [11:0]         o;
	logic [47:0]         expq[$];
	int                  fail_count = 0;
	int                  num_checks = 0;
	initial forever #20 mclk = ~mclk;
	mdsl_top DUT (.mclk, .rstn, .enable_pin(en), .mode_pin(md), .out_near_in(near),
		.sel_match(match), .vin_mv(vin), .vsup_mv(vsup), .apb_psel(req[41]),
		.apb_penable(pen), .apb_pwrite(req[40]), .apb_paddr(req[39:32]),
		.apb_pwdata(req[31:0]), .apb_prdata(prdata), .apb_pready(pready),
		.apb_pslverr(pslverr), .probe_sel(sel), .probe_opt(opt), .probe_active(act),
		.ctl, .charge_termination_level(lt), .charge_current_level(lc),
		.boost_target_level(lb));
	mdsl_partner u_far (.mclk, .probe_active(act), .probe_sel(sel), .probe_opt(opt),
		.res_opt(res), .sel_match(match));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	always @(posedge mclk) if (req[41] && pen && pready && !req[40])
		chk("apb read", expq.pop_front(), {pslverr, prdata});
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		req <= {1'b1, w, a, d};
		@(posedge mclk);
		pen <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		req <= '0;
		pen <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [32:0] e);
		expq.push_back(48'(e));
		apb(1'b0, a, 32'h0);
	endtask
	task automatic drive(logic m, logic [15:0] vi, logic [15:0] vs, logic [3:0] e);
		@(posedge mclk);
		md <= m;
		vin <= vi;
		vsup <= vs;
		repeat (2) @(posedge mclk);
		#1 chk("ctl", 48'(e), 48'(ctl));
	endtask
	task automatic levels(logic [11:0] x);
		#1 chk("levels", {mdsl_pkg::TERM_MV[x[11:8]], mdsl_pkg::CURR_DMA[x[7:4]],
			mdsl_pkg::BOOST_MV[x[3:0]]}, {lt, lc, lb});
	endtask
	// enable toggle re-arms detection; levels must clear meanwhile
	task automatic detect(logic [11:0] x);
		@(posedge mclk);
		en <= 1'b0;
		near <= 1'b0;
		res <= x;
		repeat (3) @(posedge mclk);
		#1 chk("cleared", 48'h0, {lt, lc, lb});
		@(posedge mclk);
		en <= 1'b1;
		repeat (5) @(posedge mclk);
		near <= 1'b1;
		wait (lt !== 16'h0);
		repeat (2) @(posedge mclk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hc2ff));
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			{en, md} <= 2'(i);
			repeat (2) @(posedge mclk);
			#1 chk("pin modes", 48'(i == 1 ? 4'b0001 : 4'b1000), 48'(ctl));
		end
		$display("test pin modes done");
		o = {4'($urandom), 4'($urandom_range(15, 1)), 4'($urandom)};
		t = mdsl_pkg::TERM_MV[o[11:8]];
		detect(o);
		levels(o);
		rd(8'h04, 33'(o));
		@(posedge mclk);
		res <= ~o;
		repeat (600) @(posedge mclk);
		levels(o);
		$display("test detection done");
		drive(1'b1, mdsl_pkg::BOOST_MV[o[3:0]] - 16'h1, 16'h0, 4'b0100);
		drive(1'b1, mdsl_pkg::BOOST_MV[o[3:0]] + 16'h65, 16'h0, 4'b1010);
		drive(1'b0, 16'h1518, 16'h0, 4'b1010);
		drive(1'b0, 16'h1518, t, 4'b1000);
		drive(1'b0, 16'h1518, t - 16'h46, 4'b1000);
		drive(1'b0, 16'h1518, t - 16'h50, 4'b1010);
		$display("test charge control done");
		detect(12'h00f);
		levels(12'h00f);
		rd(8'h04, 33'h00f);
		// status: drop flag set, forced buck, done, bypass only as current option is 0
		rd(8'h00, {23'h000000, 1'b1, (t - 16'h0050) < mdsl_pkg::TERM_MV[0], 8'hb8});
		apb(1'b1, 8'h08, 32'h1);
		rd(8'h00, {23'h000000, 1'b0, (t - 16'h0050) < mdsl_pkg::TERM_MV[0], 8'hb8});
		rd(8'h0c, {1'b1, 32'h0});
		$display("test refresh done");
		tally_and_finish();
	end
endmodule
